// ===== core/cgsa_hist_mem.sv
`timescale 1ns/1ps
`include "cgsa_params.svh"
module cgsa_hist_mem (
   input  wire logic                    clk,
   input  wire logic                    wr_en,
   input  wire cgsa_pkg::cgsa_ch_t      wr_addr,
   input  wire logic [`CGSA_CNT_W-1:0]  wr_data,
   input  wire cgsa_pkg::cgsa_ch_t      rd_addr,
   output logic      [`CGSA_CNT_W-1:0]  rd_data
);
   import cgsa_pkg::*;
   // Full resolution histogram, one 32-bit count per channel
   logic [`CGSA_CNT_W-1:0] mem_r [`CGSA_HIST_CH];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
      rd_data <= mem_r[rd_addr];
   end
endmodule // cgsa_hist_mem

// ===== core/cgsa_params.svh
`ifndef CGSA_PARAMS_SVH
`define CGSA_PARAMS_SVH
`define CGSA_CLK_NS            5
`define CGSA_MAX_DLY_NS        51000
`define CGSA_MAX_DLY_CYC       (`CGSA_MAX_DLY_NS / `CGSA_CLK_NS)
`define CGSA_TICK_NS           200
`define CGSA_TICK_CYC          (`CGSA_TICK_NS / `CGSA_CLK_NS)
`define CGSA_PRESET_STEP_NS    10000000
`define CGSA_PRESET_STEP_TICKS (`CGSA_PRESET_STEP_NS / `CGSA_TICK_NS)
`define CGSA_HIST_CH           16384
`define CGSA_CH_W              14
`define CGSA_CNT_W             32
`define CGSA_DLY_W             14
`define CGSA_TIME_W            48
`define CGSA_OFF_CTRL          8'h00
`define CGSA_OFF_STATUS        8'h04
`define CGSA_OFF_GATE_DLY      8'h08
`define CGSA_OFF_WIN_LEN       8'h0C
`define CGSA_OFF_PEAK_DLY      8'h10
`define CGSA_OFF_PRESET        8'h14
`define CGSA_OFF_REAL_LO       8'h18
`define CGSA_OFF_REAL_HI       8'h1C
`define CGSA_OFF_LIVE_LO       8'h20
`define CGSA_OFF_LIVE_HI       8'h24
`define CGSA_OFF_RATE          8'h28
`define CGSA_OFF_PILEUP        8'h2C
`define CGSA_OFF_PU_CFG        8'h30
`define CGSA_OFF_HIST_ADDR     8'h34
`define CGSA_OFF_HIST_DATA     8'h38
`define CGSA_CTRL_RUN          0
`define CGSA_CTRL_CLEAR        1
`define CGSA_CTRL_ANALOG       2
`define CGSA_CTRL_EDGE_MODE    3
`define CGSA_CTRL_FALLING      4
`define CGSA_CTRL_ANTI         5
`define CGSA_CTRL_ACT_LOW      6
`define CGSA_CTRL_PRESET_LIVE  7
`define CGSA_CTRL_RATE_MAIN    8
`define CGSA_RST_CFG           7'h00
`define CGSA_RST_DLY           14'h0001
`define CGSA_RST_PU_MIN        16'h0010
`define CGSA_RST_PU_MAXW       16'h0020
`define CGSA_SYNC_RST          2'h2
`endif

// ===== core/cgsa_pkg.sv
package cgsa_pkg;
   typedef logic [13:0] cgsa_ch_t;
   typedef logic [13:0] cgsa_dly_t;
   typedef enum logic [0:0] {
      CGSA_MS_ACQ   = 1'b0,
      CGSA_MS_CLEAR = 1'b1
   } cgsa_mem_st_t;
endpackage

// ===== core/cgsa_top.sv
// The APB slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "cgsa_params.svh"
module cgsa_top #(
   parameter logic [13:0] MAX_DLY_CYC       = 14'(`CGSA_MAX_DLY_CYC),
   parameter logic [47:0] PRESET_STEP_TICKS = 48'(`CGSA_PRESET_STEP_TICKS)
) (
   input  wire logic               pclk,
   input  wire logic               presetn,
   input  wire logic [7:0]         paddr,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic      [31:0]        prdata,
   output logic                    pslverr,
   input  wire logic               gate_logic_input,
   input  wire logic               veto_input_n,
   input  wire logic               peak_in,
   input  wire cgsa_pkg::cgsa_ch_t amp_ch,
   input  wire logic               fast_disc,
   input  wire logic               main_pulse,
   output logic                    baseline_hold,
   output logic                    acc_event
);
   import cgsa_pkg::*;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      return a == off;
   endfunction

   function automatic cgsa_dly_t clamp(input cgsa_dly_t d, input cgsa_dly_t mx);
      return (d == 14'h0000) ? 14'h0001 : ((d > mx) ? mx : d);
   endfunction

   // Input synchronisers: gate on index 0, veto on index 1
   logic       sync1_r [2];
   logic       sync2_r [2];
   wire  [1:0] async_in = {veto_input_n, gate_logic_input};
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               sync1_r[gi] <= 1'(`CGSA_SYNC_RST >> gi);
               sync2_r[gi] <= 1'(`CGSA_SYNC_RST >> gi);
            end else begin
               sync1_r[gi] <= async_in[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate
   wire gate_s   = sync2_r[0];
   wire veto_act = !sync2_r[1];

   // Configuration and status registers
   logic [6:0]             cfg_r;
   logic                   run_r, done_r;
   cgsa_dly_t              gd_r, wl_r, pd_r, hist_addr_r;
   logic [31:0]            preset_r, rate_r, pu_cnt_r;
   logic [15:0]            pu_min_r, pu_maxw_r;
   logic [`CGSA_TIME_W-1:0] real_r, live_r;
   logic                   pready_r, pslverr_r, rd_ok_r;
   logic [31:0]            prdata_r;
   cgsa_mem_st_t           ms_r;
   cgsa_ch_t               clr_addr_r;
   logic [`CGSA_CNT_W-1:0] mem_rd;

   wire bypass    = cfg_r[`CGSA_CTRL_ANALOG - 2];
   wire edge_mode = cfg_r[`CGSA_CTRL_EDGE_MODE - 2];
   wire falling   = cfg_r[`CGSA_CTRL_FALLING - 2];
   wire anti      = cfg_r[`CGSA_CTRL_ANTI - 2];
   wire act_low   = cfg_r[`CGSA_CTRL_ACT_LOW - 2];
   wire pre_live  = cfg_r[`CGSA_CTRL_PRESET_LIVE - 2];
   wire rate_main = cfg_r[`CGSA_CTRL_RATE_MAIN - 2];

   // APB decode
   wire apb_acc   = psel & penable;
   wire xfer_done = apb_acc & pready_r;
   wire wr_done   = xfer_done & pwrite;
   wire wr_ctrl   = wr_done & hit(paddr, `CGSA_OFF_CTRL);
   wire wr_haddr  = wr_done & hit(paddr, `CGSA_OFF_HIST_ADDR);
   wire clr_cmd   = wr_ctrl & pwdata[`CGSA_CTRL_CLEAR];
   wire start_cmd = wr_ctrl & pwdata[`CGSA_CTRL_RUN];
   wire hd_sel    = hit(paddr, `CGSA_OFF_HIST_DATA);
   wire rd_ready  = pwrite | !hd_sel | rd_ok_r;
   logic        mapped;
   logic [31:0] rd_mux;
   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (paddr)
         `CGSA_OFF_CTRL:      rd_mux = {23'h0, cfg_r, 1'b0, run_r};
         `CGSA_OFF_STATUS:    rd_mux = {28'h0, veto_act, ms_r == CGSA_MS_CLEAR, done_r, run_r};
         `CGSA_OFF_GATE_DLY:  rd_mux = {18'h0, gd_r};
         `CGSA_OFF_WIN_LEN:   rd_mux = {18'h0, wl_r};
         `CGSA_OFF_PEAK_DLY:  rd_mux = {18'h0, pd_r};
         `CGSA_OFF_PRESET:    rd_mux = preset_r;
         `CGSA_OFF_REAL_LO:   rd_mux = real_r[31:0];
         `CGSA_OFF_REAL_HI:   rd_mux = {16'h0, real_r[47:32]};
         `CGSA_OFF_LIVE_LO:   rd_mux = live_r[31:0];
         `CGSA_OFF_LIVE_HI:   rd_mux = {16'h0, live_r[47:32]};
         `CGSA_OFF_RATE:      rd_mux = rate_r;
         `CGSA_OFF_PILEUP:    rd_mux = pu_cnt_r;
         `CGSA_OFF_PU_CFG:    rd_mux = {pu_maxw_r, pu_min_r};
         `CGSA_OFF_HIST_ADDR: rd_mux = {18'h0, hist_addr_r};
         `CGSA_OFF_HIST_DATA: rd_mux = mem_rd;
         default:             mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (apb_acc && !pready_r && rd_ready) begin
         pready_r  <= 1'b1;
         prdata_r  <= (pwrite || !mapped) ? 32'h0000_0000 : rd_mux;
         pslverr_r <= !mapped;
      end else begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end
   assign pready  = pready_r;
   assign prdata  = prdata_r;
   assign pslverr = pslverr_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r       <= `CGSA_RST_CFG;
         gd_r        <= `CGSA_RST_DLY;
         wl_r        <= `CGSA_RST_DLY;
         pd_r        <= `CGSA_RST_DLY;
         preset_r    <= 32'h0000_0000;
         pu_min_r    <= `CGSA_RST_PU_MIN;
         pu_maxw_r   <= `CGSA_RST_PU_MAXW;
         hist_addr_r <= 14'h0000;
      end else if (wr_done) begin
         if (wr_ctrl) cfg_r <= pwdata[8:2];
         if (hit(paddr, `CGSA_OFF_GATE_DLY)) gd_r <= pwdata[13:0];
         if (hit(paddr, `CGSA_OFF_WIN_LEN)) wl_r <= pwdata[13:0];
         if (hit(paddr, `CGSA_OFF_PEAK_DLY)) pd_r <= pwdata[13:0];
         if (hit(paddr, `CGSA_OFF_PRESET)) preset_r <= pwdata;
         if (hit(paddr, `CGSA_OFF_PU_CFG)) begin
            pu_min_r  <= pwdata[15:0];
            pu_maxw_r <= pwdata[31:16];
         end
         if (wr_haddr) hist_addr_r <= pwdata[13:0];
      end
   end

   wire cgsa_dly_t gd_eff = clamp(gd_r, MAX_DLY_CYC);
   wire cgsa_dly_t wl_eff = clamp(wl_r, MAX_DLY_CYC);
   wire cgsa_dly_t pd_eff = clamp(pd_r, MAX_DLY_CYC);

   // Gate delay line
   logic [`CGSA_HIST_CH-1:0] line_r;
   cgsa_dly_t                wp_r, win_cnt_r;
   logic                     gate_dly_d_r;
   wire cgsa_dly_t rp       = wp_r - gd_eff;
   wire gate_dly            = line_r[rp];
   wire gate_rise           = gate_dly & !gate_dly_d_r;
   wire gate_fall           = !gate_dly & gate_dly_d_r;
   wire gate_edge           = falling ? gate_fall : gate_rise;
   wire win_start           = edge_mode & gate_edge;
   wire window              = edge_mode ? (win_cnt_r != 14'h0000)
                                        : (gate_dly ^ act_low);
   wire in_win              = anti ? !window : window;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_r       <= '0;
         wp_r         <= 14'h0000;
         gate_dly_d_r <= 1'b0;
         win_cnt_r    <= 14'h0000;
      end else begin
         line_r[wp_r] <= gate_s;
         wp_r         <= wp_r + 14'h0001;
         gate_dly_d_r <= gate_dly;
         if (win_start) win_cnt_r <= wl_eff;
         else if (win_cnt_r != 14'h0000) win_cnt_r <= win_cnt_r - 14'h0001;
      end
   end

   // Peak pulse shaping, pile-up inspection and delayed event
   logic        peak_d_r, fast_d_r, pu_r, pend_v_r, pend_pu_r, inc_v_r;
   logic [15:0] since_r, width_r;
   cgsa_dly_t   pend_cnt_r;
   cgsa_ch_t    pend_ch_r, inc_addr_r;
   wire peak_pulse = peak_in & !peak_d_r;
   wire fast_rise  = fast_disc & !fast_d_r;
   wire pu_int     = fast_rise & (since_r < pu_min_r);
   wire pu_wid     = fast_disc & (width_r == pu_maxw_r);
   wire pu_set     = pu_int | pu_wid;
   wire pend_fire  = pend_v_r & (pend_cnt_r == 14'h0000);
   wire acc_evt    = pend_fire & run_r & !veto_act & !pend_pu_r & (ms_r == CGSA_MS_ACQ)
                     & (bypass | in_win);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peak_d_r   <= 1'b0;
         fast_d_r   <= 1'b0;
         pu_r       <= 1'b0;
         since_r    <= 16'hFFFF;
         width_r    <= 16'h0000;
         pend_v_r   <= 1'b0;
         pend_pu_r  <= 1'b0;
         pend_cnt_r <= 14'h0000;
         pend_ch_r  <= 14'h0000;
         inc_v_r    <= 1'b0;
         inc_addr_r <= 14'h0000;
         acc_event  <= 1'b0;
      end else begin
         peak_d_r <= peak_in;
         fast_d_r <= fast_disc;
         if (fast_rise) since_r <= 16'h0000;
         else if (since_r != 16'hFFFF) since_r <= since_r + 16'h0001;
         width_r <= fast_disc ? ((width_r == 16'hFFFF) ? width_r : width_r + 16'h0001)
                              : 16'h0000;
         if (peak_pulse) begin
            pend_v_r   <= 1'b1;
            pend_cnt_r <= pd_eff - 14'h0001;
            pend_ch_r  <= amp_ch;
            pend_pu_r  <= pu_r | pu_set | (pend_v_r & !pend_fire);
            pu_r       <= 1'b0;
         end else begin
            if (pu_set) pu_r <= 1'b1;
            if (pend_fire) pend_v_r <= 1'b0;
            else if (pend_v_r) pend_cnt_r <= pend_cnt_r - 14'h0001;
         end
         inc_v_r    <= acc_evt;
         inc_addr_r <= pend_ch_r;
         acc_event  <= acc_evt;
      end
   end

   // Histogram: read-modify-write increment, sweep clear
   wire cgsa_ch_t mem_ra  = acc_evt ? pend_ch_r : hist_addr_r;
   wire           mem_we  = (ms_r == CGSA_MS_CLEAR) | inc_v_r;
   wire cgsa_ch_t mem_wa  = (ms_r == CGSA_MS_CLEAR) ? clr_addr_r : inc_addr_r;
   wire [31:0]    mem_inc = (&mem_rd) ? mem_rd : mem_rd + 32'h0000_0001;
   wire [31:0]    mem_wd  = (ms_r == CGSA_MS_CLEAR) ? 32'h0000_0000 : mem_inc;
   cgsa_hist_mem u_mem (
      .clk     (pclk),
      .wr_en   (mem_we),
      .wr_addr (mem_wa),
      .wr_data (mem_wd),
      .rd_addr (mem_ra),
      .rd_data (mem_rd)
   );
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ms_r       <= CGSA_MS_ACQ;
         clr_addr_r <= 14'h0000;
         rd_ok_r    <= 1'b0;
      end else begin
         rd_ok_r <= !acc_evt & !wr_haddr;
         case (ms_r)
            CGSA_MS_ACQ: begin
               clr_addr_r <= 14'h0000;
               if (clr_cmd) ms_r <= CGSA_MS_CLEAR;
            end
            CGSA_MS_CLEAR: begin
               clr_addr_r <= clr_addr_r + 14'h0001;
               if (&clr_addr_r) ms_r <= CGSA_MS_ACQ;
            end
            default: ms_r <= CGSA_MS_ACQ;
         endcase
      end
   end

   // Timers, preset stop and incoming rate
   logic [5:0]  tick_cnt_r;
   wire         tick       = (tick_cnt_r == 6'(`CGSA_TICK_CYC - 1));
   wire [47:0]  preset_tk  = {16'h0000, preset_r} * PRESET_STEP_TICKS;
   wire [47:0]  run_time   = pre_live ? live_r : real_r;
   wire         preset_hit = run_r & (preset_r != 32'h0000_0000)
                             & (run_time >= preset_tk);
   wire         rate_src   = rate_main ? (main_pulse & run_r) : (fast_rise & run_r);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt_r    <= 6'h00;
         real_r        <= 48'h0000_0000_0000;
         live_r        <= 48'h0000_0000_0000;
         run_r         <= 1'b0;
         done_r        <= 1'b0;
         rate_r        <= 32'h0000_0000;
         pu_cnt_r      <= 32'h0000_0000;
         baseline_hold <= 1'b0;
      end else begin
         tick_cnt_r    <= tick ? 6'h00 : tick_cnt_r + 6'h01;
         baseline_hold <= veto_act;
         if (clr_cmd) begin
            real_r   <= 48'h0000_0000_0000;
            live_r   <= 48'h0000_0000_0000;
            rate_r   <= 32'h0000_0000;
            pu_cnt_r <= 32'h0000_0000;
         end else begin
            if (run_r && tick) real_r <= real_r + 48'h0000_0000_0001;
            if (run_r && tick && !veto_act) live_r <= live_r + 48'h0000_0000_0001;
            rate_r <= rate_r + {31'h0, rate_src} + {31'h0, pu_wid & run_r};
            if (run_r && pend_fire && pend_pu_r) pu_cnt_r <= pu_cnt_r + 32'h0000_0001;
         end
         if (preset_hit) begin
            run_r  <= 1'b0;
            done_r <= 1'b1;
         end else if (wr_ctrl) begin
            run_r <= pwdata[`CGSA_CTRL_RUN];
            if (start_cmd) done_r <= 1'b0;
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_fire_ok;
      pend_fire && run_r && !veto_act && !pend_pu_r && ms_r == CGSA_MS_ACQ;
   endsequence
   sequence s_incr;
      ##1 inc_v_r && mem_we && mem_wa == $past(pend_ch_r);
   endsequence
   a_peak_one_wide: assert property (peak_pulse |=> !peak_pulse)
      else $error("peak pulse longer than one cycle");
   a_gate_logic_input_inside: assert property (acc_evt && !bypass && !anti |-> window)
      else $error("coincidence event outside window");
   a_anti_outside: assert property (acc_evt && !bypass && anti |-> !window)
      else $error("anti-coincidence event inside window");
   a_bypass_accept: assert property (s_fire_ok ##0 bypass |-> acc_evt)
      else $error("bypass did not accept event");
   a_veto_blocks: assert property (veto_act |-> !acc_evt)
      else $error("event accepted during veto");
   a_live_frozen: assert property (veto_act && !clr_cmd |=> live_r == $past(live_r))
      else $error("live timer moved during veto");
   a_hist_incr: assert property (acc_evt |-> s_incr)
      else $error("accepted event not written to histogram");
   a_win_open: assert property (win_start |=> win_cnt_r == $past(wl_eff) && window)
      else $error("window did not open on selected edge");
   a_peak_delay: assert property (peak_pulse |=>
                                  pend_v_r && pend_cnt_r == $past(pd_eff) - 14'h0001)
      else $error("peak delay load wrong");
   a_pileup_rej: assert property (pend_fire && pend_pu_r |-> !acc_evt)
      else $error("piled-up event accepted");
   a_preset_stop: assert property (preset_hit |=> !run_r && done_r)
      else $error("preset expiry did not stop acquisition");
endmodule // cgsa_top

// ===== sim/cgsa_gate_src.sv
`timescale 1ns/1ps
module cgsa_gate_src (
   input  wire logic pclk,
   input  wire logic lvl_req,
   output logic      gate
);
   initial gate = 1'b0;
   always @(posedge pclk) begin
      gate <= lvl_req;
   end
endmodule // cgsa_gate_src

// ===== sim/cgsa_top_tb.sv
`timescale 1ns/1ps
`include "cgsa_params.svh"
module cgsa_top_tb;
   import cgsa_pkg::*;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   logic        gate_req = 1'b0;
   logic        gate;
   logic        veto_input_n = 1'b1;
   logic        peak_in = 1'b0;
   cgsa_ch_t    amp_ch = 14'h0;
   logic        fast_disc = 1'b0;
   logic        main_pulse = 1'b0;
   logic        baseline_hold;
   logic        acc_event;
   logic [31:0] rd;
   logic        er;
   int          error_cnt = 0;
   int          num_checks = 0;
   int          n0, n1, n2;

   always #2.5 pclk = ~pclk;

   cgsa_gate_src u_src (.pclk(pclk), .lvl_req(gate_req), .gate(gate));

   cgsa_top #(.MAX_DLY_CYC(14'h64), .PRESET_STEP_TICKS(48'h2)) u_dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .gate_logic_input(gate), .veto_input_n(veto_input_n),
      .peak_in(peak_in), .amp_ch(amp_ch), .fast_disc(fast_disc),
      .main_pulse(main_pulse), .baseline_hold(baseline_hold), .acc_event(acc_event)
   );

   task automatic print_verdict;
      $display("checks=%0d errors=%0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // APB transfer, held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic hist(input cgsa_ch_t ch, input logic [31:0] exp);
      wr(`CGSA_OFF_HIST_ADDR, {18'h0, ch});
      rdc(`CGSA_OFF_HIST_DATA, exp);
   endtask

   // One timing pulse; n counts cycles until the accepted-event pulse
   task automatic ev(input cgsa_ch_t ch, input logic acc, output int n);
      logic got;
      got = 1'b0;
      n = 0;
      peak_in <= 1'b1;
      amp_ch <= ch;
      repeat (150) begin
         @(posedge pclk);
         peak_in <= 1'b0;
         if (acc_event === 1'b1) got = 1'b1;
         if (!got) n++;
      end
      chk({31'h0, got}, {31'h0, acc});
   endtask

   task automatic t_regs;
      rdc(`CGSA_OFF_GATE_DLY, 32'h1);
      rdc(`CGSA_OFF_PU_CFG, 32'h0020_0010);
      apb(1'b0, 8'h3C, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
   endtask

   task automatic t_clear;
      int k;
      k = 0;
      wr(`CGSA_OFF_CTRL, 32'h2);
      do begin
         apb(1'b0, `CGSA_OFF_STATUS, 32'h0);
         k++;
      end while (rd[2] !== 1'b0 && k < 6000);
      chk({31'h0, rd[2]}, 32'h0);
   endtask

   task automatic t_preset;
      wr(`CGSA_OFF_PRESET, 32'h1);
      wr(`CGSA_OFF_CTRL, 32'h1);
      repeat (200) @(posedge pclk);
      rdc(`CGSA_OFF_STATUS, 32'h2);
      rdc(`CGSA_OFF_REAL_LO, 32'h2);
      rdc(`CGSA_OFF_LIVE_LO, 32'h2);
      veto_input_n <= 1'b0;
      wr(`CGSA_OFF_PRESET, 32'h2);
      wr(`CGSA_OFF_CTRL, 32'h81);
      repeat (200) @(posedge pclk);
      rdc(`CGSA_OFF_STATUS, 32'h9);
      veto_input_n <= 1'b1;
      repeat (200) @(posedge pclk);
      rdc(`CGSA_OFF_STATUS, 32'h2);
      rdc(`CGSA_OFF_LIVE_LO, 32'h4);
      wr(`CGSA_OFF_PRESET, 32'h0);
   endtask

   task automatic t_delay;
      wr(`CGSA_OFF_CTRL, 32'h5);
      wr(`CGSA_OFF_PEAK_DLY, 32'h0);
      ev(14'h1, 1'b1, n0);
      wr(`CGSA_OFF_PEAK_DLY, 32'h5);
      ev(14'h1, 1'b1, n1);
      wr(`CGSA_OFF_PEAK_DLY, 32'h14);
      ev(14'h1, 1'b1, n2);
      chk(32'(n1 - n0), 32'h4);
      chk(32'(n2 - n1), 32'hF);
      hist(14'h1, 32'h3);
      wr(`CGSA_OFF_PEAK_DLY, 32'h5);
   endtask

   task automatic t_level;
      for (int i = 0; i < 8; i++) begin
         gate_req <= i[0];
         wr(`CGSA_OFF_CTRL, 32'h1 | (32'(i[1]) << 6) | (32'(i[2]) << 5));
         repeat (10) @(posedge pclk);
         ev(14'h3FFF, i[0] ^ i[1] ^ i[2], n0);
      end
      hist(14'h3FFF, 32'h4);
   endtask

   task automatic t_gdly;
      wr(`CGSA_OFF_GATE_DLY, 32'h3C);
      gate_req <= 1'b0;
      wr(`CGSA_OFF_CTRL, 32'h1);
      repeat (80) @(posedge pclk);
      gate_req <= 1'b1;
      ev(14'h3, 1'b0, n0);
      ev(14'h3, 1'b1, n0);
      wr(`CGSA_OFF_GATE_DLY, 32'h1);
   endtask

   task automatic t_edge;
      wr(`CGSA_OFF_WIN_LEN, 32'hA);
      for (int e = 0; e < 2; e++) begin
         gate_req <= e[0];
         repeat (30) @(posedge pclk);
         wr(`CGSA_OFF_CTRL, 32'h9 | (32'(e) << 4));
         repeat (30) @(posedge pclk);
         gate_req <= !e[0];
         repeat (2) @(posedge pclk);
         ev(14'h4, 1'b1, n0);
         gate_req <= e[0];
         repeat (30) @(posedge pclk);
         gate_req <= !e[0];
         repeat (14) @(posedge pclk);
         ev(14'h4, 1'b0, n0);
      end
      hist(14'h4, 32'h2);
   endtask

   task automatic t_veto;
      wr(`CGSA_OFF_CTRL, 32'h5);
      veto_input_n <= 1'b0;
      repeat (5) @(posedge pclk);
      chk({31'h0, baseline_hold}, 32'h1);
      rdc(`CGSA_OFF_STATUS, 32'h9);
      ev(14'h5, 1'b0, n0);
      veto_input_n <= 1'b1;
      repeat (5) @(posedge pclk);
      chk({31'h0, baseline_hold}, 32'h0);
      ev(14'h5, 1'b1, n0);
   endtask

   task automatic t_rate;
      wr(`CGSA_OFF_CTRL, 32'h101);
      main_pulse <= 1'b1;
      repeat (3) @(posedge pclk);
      main_pulse <= 1'b0;
      repeat (5) @(posedge pclk);
      rdc(`CGSA_OFF_RATE, 32'h3);
      wr(`CGSA_OFF_CTRL, 32'h1);
      fast_disc <= 1'b1;
      repeat (40) @(posedge pclk);
      fast_disc <= 1'b0;
      main_pulse <= 1'b1;
      repeat (2) @(posedge pclk);
      main_pulse <= 1'b0;
      repeat (5) @(posedge pclk);
      rdc(`CGSA_OFF_RATE, 32'h5);
   endtask

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs;
      t_clear;
      t_preset;
      t_delay;
      t_level;
      t_gdly;
      t_edge;
      t_veto;
      t_rate;
      print_verdict;
   end

   initial begin
      repeat (60000) @(posedge pclk);
      error_cnt++;
      print_verdict;
   end
endmodule // cgsa_top_tb
